// >>> hw/sacs_sar_reg.v
`timescale 1ns/100ps
`include "sacs_consts.vh"
// Successive-approximation register: one decision per step enable
module sacs_sar_reg
#(
    parameter WIDTH = 12
)
(
    // Clock and reset
    input  wire             clk_i,
    input  wire             reset_i,
    // Control
    input  wire             start_i,
    input  wire             step_i,
    input  wire             cmp_hi_i,
    // Result
    output reg  [WIDTH-1:0] trial_o,
    output reg  [WIDTH-1:0] result_o
);
    reg [WIDTH-1:0] bit_mask;
    // Trial bit walks from the MSB down; comparator keeps or drops it
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            trial_o  <= {WIDTH{1'b0}};
            bit_mask <= {WIDTH{1'b0}};
            result_o <= {WIDTH{1'b0}};
        end
        else if (start_i)
        begin
            trial_o  <= {1'b1, {(WIDTH-1){1'b0}}};
            bit_mask <= {1'b1, {(WIDTH-1){1'b0}}};
        end
        else if (step_i && (bit_mask != {WIDTH{1'b0}}))
        begin
            if (bit_mask[0])
                result_o <= cmp_hi_i ? trial_o : (trial_o & ~bit_mask);
            trial_o  <= (cmp_hi_i ? trial_o : (trial_o & ~bit_mask))
                        | (bit_mask >> 1);
            bit_mask <= bit_mask >> 1;
        end
    end
endmodule // sacs_sar_reg

// >>> hw/sacs_sequencer.v
`timescale 1ns/100ps
`include "sacs_consts.vh"
module sacs_sequencer
#(
    parameter RES_BITS   = 12,
    parameter CONV_STEPS = `SACS_CONV_CYCLES,
    parameter ACQ_FALLS  = `SACS_ACQ_FALLS,
    parameter INT_DIV    = `SACS_INT_DIV
)
(
    // Clock and reset
    input  wire       clk_i,
    input  wire       reset_i,
    // Host parallel port, active-low strobes
    input  wire       cs_n_i,
    input  wire       wr_n_i,
    input  wire       rd_n_i,
    input  wire       upper_byte_select_i,
    input  wire [7:0] data_i,
    output reg  [7:0] data_o,
    output reg        data_oe_o,
    output reg        done_n_o,
    output reg        done_oe_o,
    // External conversion clock pin
    input  wire       conv_clk_pin_i,
    // Analog front-end control
    input  wire       comparator_i,
    output reg        track_o,
    output reg        sample_o,
    output reg  [3:0] pos_sel_o,
    output reg  [3:0] neg_sel_o,
    output reg        unipolar_o,
    output reg  [RES_BITS-1:0] dac_code_o,
    output reg        converting_o,
    output reg  [1:0] power_clock_mode_o
);
    localparam ST_IDLE = 2'h0;
    localparam ST_ACQ  = 2'h1;
    localparam ST_CONV = 2'h2;
    localparam ST_EXT  = 2'h3;
    localparam COM_SEL = 4'h8;

    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [7:0]  ctrl;
    reg         ext_clk_sel;
    reg         wr_d;
    reg         rd_d;
    reg         pin_d;
    reg  [7:0]  div_cnt;
    reg         osc;
    reg  [3:0]  cnt;
    reg         sar_start;
    wire        wr_rise;
    wire        rd_fall;
    wire        pin_fall;
    wire        osc_fall;
    wire        clk_fall;
    wire        acq_ext;
    wire        sar_step;
    wire [RES_BITS-1:0] trial;
    wire [RES_BITS-1:0] result;

    // Strobe edge detection, qualified by chip select
    assign wr_rise  = wr_n_i & ~wr_d & ~cs_n_i;
    assign rd_fall  = ~rd_n_i & rd_d & ~cs_n_i;
    assign pin_fall = ~conv_clk_pin_i & pin_d;
    assign osc_fall = (div_cnt == 8'h00) & osc;
    assign clk_fall = ext_clk_sel ? pin_fall : osc_fall;
    assign acq_ext  = data_i[`SACS_ACQ_BIT];
    // First conversion clock only lets the DAC settle on the MSB trial
    assign sar_step = (state == ST_CONV) & clk_fall
                    & (cnt != CONV_STEPS[3:0] - 4'h1);

    // Edge history registers
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wr_d  <= 1'b1;
            rd_d  <= 1'b1;
            pin_d <= 1'b0;
        end
        else
        begin
            wr_d  <= wr_n_i;
            rd_d  <= rd_n_i;
            pin_d <= conv_clk_pin_i;
        end
    end

    // On-chip oscillator built from a divider of the system clock
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            div_cnt <= 8'h00;
            osc     <= 1'b0;
        end
        else if (div_cnt == 8'h00)
        begin
            div_cnt <= INT_DIV[7:0] - 8'h01;
            osc     <= ~osc;
        end
        else
            div_cnt <= div_cnt - 8'h01;
    end

    // Control byte capture and clock mode retention
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ctrl        <= `SACS_CTRL_RESET;
            ext_clk_sel <= 1'b1;
        end
        else if (wr_rise)
        begin
            ctrl <= data_i;
            if (data_i[`SACS_PCM_HI])
                ext_clk_sel <= data_i[`SACS_PCM_LO];
        end
    end

    // Next-state logic of the acquisition/conversion sequencer
    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (wr_rise)
                    next_state = acq_ext ? ST_EXT : ST_ACQ;
            ST_ACQ:
                if (wr_rise)
                    next_state = acq_ext ? ST_EXT : ST_ACQ;
                else if (clk_fall && cnt == ACQ_FALLS[3:0] - 4'h1)
                    next_state = ST_CONV;
            ST_EXT:
                if (wr_rise)
                    next_state = acq_ext ? ST_EXT : ST_CONV;
            ST_CONV:
                if (wr_rise)
                    next_state = acq_ext ? ST_EXT : ST_ACQ;
                else if (clk_fall && cnt == 4'h0)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    // State, cycle counter and sampling strobe
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state     <= ST_IDLE;
            cnt       <= 4'h0;
            sar_start <= 1'b0;
            sample_o  <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            sar_start <= 1'b0;
            sample_o  <= 1'b0;
            if (next_state == ST_CONV && state != ST_CONV)
            begin
                cnt       <= CONV_STEPS[3:0] - 4'h1;
                sar_start <= 1'b1;
                sample_o  <= 1'b1;
            end
            else if (next_state == ST_ACQ && (state != ST_ACQ || wr_rise))
                cnt <= 4'h0;
            else if (clk_fall && state == ST_ACQ)
                cnt <= cnt + 4'h1;
            else if (clk_fall && state == ST_CONV && cnt != 4'h0)
                cnt <= cnt - 4'h1;
        end
    end

    // Track/hold switch and conversion flag
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            track_o      <= 1'b0;
            converting_o <= 1'b0;
        end
        else
        begin
            track_o      <= (next_state == ST_ACQ) | (next_state == ST_EXT);
            converting_o <= (next_state == ST_CONV);
        end
    end

    // Multiplexer routing and polarity from the stored byte
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pos_sel_o          <= 4'h0;
            neg_sel_o          <= COM_SEL;
            unipolar_o         <= 1'b0;
            power_clock_mode_o <= `SACS_PCM_EXT_CLK;
        end
        else
        begin
            unipolar_o         <= ctrl[`SACS_UNI_BIT];
            power_clock_mode_o <= ctrl[`SACS_PCM_HI:`SACS_PCM_LO];
            if (ctrl[`SACS_SGL_BIT])
            begin
                pos_sel_o <= {1'b0, ctrl[`SACS_CH_HI:`SACS_CH_LO]};
                neg_sel_o <= COM_SEL;
            end
            else
            begin
                pos_sel_o <= {1'b0, ctrl[2:1], ctrl[0]};
                neg_sel_o <= {1'b0, ctrl[2:1], ~ctrl[0]};
            end
        end
    end

    // Successive-approximation core
    sacs_sar_reg
    #(
        .WIDTH    (RES_BITS)
    )
    u_sar
    (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .start_i  (sar_start),
        .step_i   (sar_step),
        .cmp_hi_i (comparator_i),
        .trial_o  (trial),
        .result_o (result)
    );

    // Trial code drives the capacitive DAC
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            dac_code_o <= {RES_BITS{1'b0}};
        else
            dac_code_o <= trial;
    end

    // Done flag: completion sets it low, read or write clears it
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            done_n_o <= 1'b1;
        else if (state == ST_CONV && next_state == ST_IDLE)
            done_n_o <= 1'b0;
        else if (rd_fall || wr_rise)
            done_n_o <= 1'b1;
    end

    // Output bus: byte select picks upper four or lower eight bits
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            data_o    <= 8'h00;
            data_oe_o <= 1'b0;
            done_oe_o <= 1'b0;
        end
        else
        begin
            data_oe_o <= ~cs_n_i & ~rd_n_i;
            done_oe_o <= ~cs_n_i;
            if (upper_byte_select_i)
                data_o <= {4'h0, result[RES_BITS-1:8]};
            else
                data_o <= result[7:0];
        end
    end
endmodule // sacs_sequencer

// >>> pkg/sacs_consts.vh
`ifndef SACS_CONSTS_VH
`define SACS_CONSTS_VH
// Control byte field positions
`define SACS_PCM_HI        7
`define SACS_PCM_LO        6
`define SACS_ACQ_BIT       5
`define SACS_SGL_BIT       4
`define SACS_UNI_BIT       3
`define SACS_CH_HI         2
`define SACS_CH_LO         0
// Power/clock mode codes
`define SACS_PCM_FULL_PD   2'h0
`define SACS_PCM_STANDBY   2'h1
`define SACS_PCM_INT_CLK   2'h2
`define SACS_PCM_EXT_CLK   2'h3
// Reset values
`define SACS_CTRL_RESET    8'hc0
// Timing counts in conversion-clock cycles
`define SACS_ACQ_FALLS     4
`define SACS_CONV_CYCLES   13
// Internal oscillator period in ns, acquisition time for reference
`define SACS_INT_OSC_NS    250
`define SACS_ACQ_INT_NS    1000
`define SACS_CLK_NS        50
// Divider count per half period of the on-chip oscillator
`define SACS_INT_HALF_NS   (`SACS_INT_OSC_NS / 2)
`define SACS_INT_DIV ((`SACS_INT_HALF_NS + `SACS_CLK_NS - 1) / `SACS_CLK_NS)
`endif

// >>> sim/sacs_host_model.sv
`timescale 1ns/100ps
// Host processor on the byte-wide port
module sacs_host_model
(
    // Clock
    input  wire       clk_i,
    // Strobes and bus
    output reg        cs_n_o,
    output reg        wr_n_o,
    output reg        rd_n_o,
    output reg        upper_byte_select_o,
    output reg  [7:0] data_o,
    input  wire [7:0] data_i
);
    // Idle bus, strobes high
    initial
    begin
        cs_n_o = 1'b1;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        upper_byte_select_o = 1'b0;
        data_o = 8'h00;
    end
    // Select and byte held over the strobe rise
    task write_byte(input [7:0] b);
    begin
        @(posedge clk_i) #2;
        cs_n_o = 1'b0;
        wr_n_o = 1'b0;
        data_o = b;
        @(posedge clk_i) #2;
        wr_n_o = 1'b1;
        @(posedge clk_i) #2;
        cs_n_o = 1'b1;
        data_o = ~b; // Released bus stops showing the byte
    end
    endtask
    // Read one half of the result
    task read_byte(input hi, output [7:0] v);
    begin
        @(posedge clk_i) #2;
        cs_n_o = 1'b0;
        rd_n_o = 1'b0;
        upper_byte_select_o = hi;
        repeat (2) @(posedge clk_i);
        #2;
        v = data_i;
        rd_n_o = 1'b1;
        cs_n_o = 1'b1;
    end
    endtask
endmodule // sacs_host_model

// >>> sim/sacs_seq_props.sv
`timescale 1ns/100ps
// Port-level checks on the sequencer
module sacs_seq_props
#(
    parameter CONV_STEPS = 13,
    parameter ACQ_FALLS  = 4
)
(
    // Clock and reset
    input wire       clk_i,
    input wire       reset_i,
    // Host port
    input wire       cs_n_i,
    input wire       wr_n_i,
    input wire       rd_n_i,
    input wire [7:0] data_i,
    input wire       done_n_o,
    // Converter side
    input wire       conv_clk_pin_i,
    input wire       track_o,
    input wire       sample_o,
    input wire [3:0] pos_sel_o,
    input wire [3:0] neg_sel_o,
    input wire       unipolar_o,
    input wire       converting_o,
    input wire [1:0] power_clock_mode_o
);
    reg       wr_q, ck_q, ext_pend, int_acq, ext_clk;
    reg [4:0] cfall, afall;
    wire      wr_ev = wr_n_i && !wr_q && !cs_n_i;
    wire      fall  = ck_q && !conv_clk_pin_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // Write events, acquisition kind and pin falls per phase
    always @(posedge clk_i or posedge reset_i)
        if (reset_i)
        begin
            wr_q     <= 1'b1;
            ck_q     <= 1'b0;
            ext_pend <= 1'b0;
            int_acq  <= 1'b0;
            ext_clk  <= 1'b1;
            cfall    <= 5'h0;
            afall    <= 5'h0;
        end
        else
        begin
            wr_q  <= wr_n_i;
            ck_q  <= conv_clk_pin_i;
            cfall <= converting_o ? cfall + fall : 5'h0;
            afall <= track_o ? afall + fall : 5'h0;
            if (wr_ev)
            begin
                ext_pend <= data_i[5];
                int_acq  <= !data_i[5] && !ext_pend;
                if (data_i[7])
                    ext_clk <= data_i[6];
            end
        end
    // Hold step: sample pulse, tracking off, conversion on
    sequence s_hold;
        sample_o && !track_o && converting_o;
    endsequence
    a_write_tracks:
        assert property (wr_ev && (data_i[5] || !ext_pend)
            |=> track_o && !converting_o && done_n_o)
        else $error("write did not start tracking");
    a_ext_hold:
        assert property (wr_ev && !data_i[5] && ext_pend |=> s_hold)
        else $error("second write did not hold");
    a_int_hold:
        assert property (int_acq && ext_clk && $rose(sample_o)
            |-> afall == ACQ_FALLS)
        else $error("hold not on fourth fall");
    a_conv_count:
        assert property (ext_clk && $fell(done_n_o) |-> cfall == CONV_STEPS)
        else $error("conversion length wrong");
    a_sample_close:
        assert property (sample_o |-> $fell(track_o) ##1 !sample_o)
        else $error("sample not at acquisition end");
    a_done_read:
        assert property ($fell(rd_n_i) && !cs_n_i && !done_n_o |=> done_n_o)
        else $error("read did not clear done");
    // Routing follows the stored byte one clock after it is taken
    a_input_route:
        assert property (wr_ev |=> ##1
            pos_sel_o == {1'b0, $past(data_i[2:0], 2)}
            && neg_sel_o == ($past(data_i[4], 2) ? 4'h8
            : {1'b0, $past(data_i[2:0], 2) ^ 3'h1})
            && unipolar_o == $past(data_i[3], 2))
        else $error("input routing wrong");
    a_mode_field:
        assert property (wr_ev |=> ##1
            power_clock_mode_o == $past(data_i[7:6], 2))
        else $error("mode field wrong");
endmodule // sacs_seq_props

bind sacs_sequencer sacs_seq_props #(.CONV_STEPS(CONV_STEPS),
    .ACQ_FALLS(ACQ_FALLS)) u_props (.clk_i, .reset_i, .cs_n_i, .wr_n_i,
    .rd_n_i, .data_i, .done_n_o, .conv_clk_pin_i, .track_o, .sample_o,
    .pos_sel_o, .neg_sel_o, .unipolar_o, .converting_o, .power_clock_mode_o);

// >>> sim/sar_adc_acq_conv_sequencer_tb_top.sv
`timescale 1ns/100ps
// Host model, clock pin and comparator around the sequencer
module sar_adc_acq_conv_sequencer_tb_top;
    reg         clk_i = 1'b0;
    reg         reset_i = 1'b1;
    reg         conv_clk_pin_i = 1'b0;
    reg  [3:0]  cdiv = 4'h0;
    reg  [11:0] target = 12'h0;
    reg  [7:0]  cur, lo, hi;
    integer     mismatches = 0;
    integer     check_count = 0;
    integer     cycles = 0;
    integer     i, n;
    wire        cs_n_i, wr_n_i, rd_n_i, upper_byte_select_i, comparator_i;
    wire        data_oe_o, done_n_o, done_oe_o, track_o, sample_o;
    wire        unipolar_o, converting_o;
    wire [7:0]  data_i, data_o;
    wire [3:0]  pos_sel_o, neg_sel_o;
    wire [11:0] dac_code_o;
    wire [1:0]  power_clock_mode_o;
    // Ideal comparator: trial kept while not above the input
    assign comparator_i = (dac_code_o <= target);
    sacs_host_model host (.clk_i, .cs_n_o(cs_n_i), .wr_n_o(wr_n_i),
        .rd_n_o(rd_n_i), .upper_byte_select_o(upper_byte_select_i),
        .data_o(data_i), .data_i(data_o));
    sacs_sequencer uut (.clk_i, .reset_i, .cs_n_i, .wr_n_i, .rd_n_i,
        .upper_byte_select_i, .data_i, .data_o, .data_oe_o, .done_n_o,
        .done_oe_o, .conv_clk_pin_i, .comparator_i, .track_o, .sample_o,
        .pos_sel_o, .neg_sel_o, .unipolar_o, .dac_code_o, .converting_o,
        .power_clock_mode_o);
    initial forever #25 clk_i = ~clk_i;
    // Pin clock at a tenth of the rate, and hang guard
    always @(posedge clk_i)
    begin
        cdiv <= (cdiv == 4'h9) ? 4'h0 : cdiv + 4'h1;
        if (cdiv == 4'h4 || cdiv == 4'h9)
            conv_clk_pin_i <= #2 ~conv_clk_pin_i;
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            mismatches = mismatches + 1;
            complete_run;
        end
    end
    function [3:0] neg_of(input [7:0] b);
        neg_of = b[4] ? 4'h8 : {1'b0, b[2:0] ^ 3'h1};
    endfunction
    task check(input [63:0] name, input [11:0] exp, input [11:0] got);
    begin
        check_count = check_count + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("Error %0s expected %h seen %h", name, exp, got);
        end
    end
    endtask
    task complete_run;
    begin
        $display("Checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    // Write, then host-timed hold when the byte asks for it
    task start(input [7:0] b);
    begin
        cur = b & 8'hdf;
        @(posedge conv_clk_pin_i);
        host.write_byte(b);
        check("track", 1, track_o);
        check("abort", 0, converting_o);
        check("wrclr", 1, done_n_o);
        if (b[5])
        begin
            repeat ($urandom % 20 + 3) @(posedge clk_i);
            @(posedge conv_clk_pin_i);
            host.write_byte(cur);
            check("hold", 0, track_o);
            check("conv", 1, converting_o);
        end
    end
    endtask
    // Wait for done, check routing and the two result halves
    task finish(input rd);
    begin
        n = 0;
        while (done_n_o !== 1'b0 && n < 600)
        begin
            @(posedge clk_i) #2;
            n = n + 1;
        end
        check("done", 0, done_n_o);
        check("pos", {1'b0, cur[2:0]}, pos_sel_o);
        check("neg", neg_of(cur), neg_sel_o);
        check("uni", cur[3], unipolar_o);
        check("mode", cur[7:6], power_clock_mode_o);
        check("oeidle", 0, data_oe_o);
        check("doeidle", 0, done_oe_o);
        if (rd)
        begin
            host.read_byte(1'b0, lo);
            check("oe", 1, data_oe_o);
            check("doe", 1, done_oe_o);
            host.read_byte(1'b1, hi);
            check("low", target[7:0], lo);
            check("high", target[11:8], hi);
            check("rdclr", 1, done_n_o);
        end
    end
    endtask
    initial
    begin
        i = $urandom(18);
        repeat (12) @(posedge clk_i);
        #2;
        reset_i = 1'b0;
        for (i = 0; i < 8; i = i + 1)
        begin
            n = $urandom;
            target = (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : n[11:0];
            start({~i[1:0], i[2], n[16:12]});
            finish(1'b1);
            $display("Test %0d finished", i);
        end
        // Abort mid conversion, then clear done by a write
        start(8'hd9);
        repeat (60) @(posedge clk_i);
        #2;
        check("running", 1, converting_o);
        target = 12'h5a3;
        start(8'hda);
        finish(1'b0);
        start(8'hcb);
        finish(1'b1);
        $display("Test abort finished");
        complete_run;
    end
endmodule // sar_adc_acq_conv_sequencer_tb_top
